// file: rtl/uart_pkg.sv
// Shared constants for the serial transceiver core
package uart_pkg;
   // -------------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------------
   localparam logic [7:0] OFF_DATA   = 8'h00;  // FIFO data window
   localparam logic [7:0] OFF_LINE_H = 8'h04;  // Frame format byte
   localparam logic [7:0] OFF_LINE_M = 8'h08;  // Divisor high byte
   localparam logic [7:0] OFF_LINE_L = 8'h0C;  // Divisor low byte
   localparam logic [7:0] OFF_CTRL   = 8'h10;  // Enable, masks, loopback
   localparam logic [7:0] OFF_STATUS = 8'h14;  // Flags, overrun clear
   localparam logic [7:0] OFF_INT    = 8'h18;  // Raw and masked requests
   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int BRK_BIT   = 0;   // Line format: send break
   localparam int PEN_BIT   = 1;   // Line format: parity enable
   localparam int EPS_BIT   = 2;   // Line format: even parity
   localparam int STP2_BIT  = 3;   // Line format: two stop bits
   localparam int FEN_BIT   = 4;   // Line format: FIFOs enabled
   localparam int WLEN_LO   = 5;   // Line format: word length, 2 bits
   localparam int EN_BIT    = 0;   // Control: core enable
   localparam int MASK_LO   = 3;   // Control: four mask bits from here
   localparam int LOOP_BIT  = 7;   // Control: loopback enable
   localparam int OVR_BIT   = 0;   // Status: overrun
   localparam int BUSY_BIT  = 3;   // Status: busy
   localparam int RXFE_BIT  = 4;   // Status: receive FIFO empty
   localparam int TXFF_BIT  = 5;   // Status: transmit FIFO full
   localparam int RXFF_BIT  = 6;   // Status: receive FIFO full
   localparam int TXFE_BIT  = 7;   // Status: transmit FIFO empty
   localparam int FE_BIT    = 8;   // Receive entry: framing error
   localparam int PE_BIT    = 9;   // Receive entry: parity error
   localparam int BE_BIT    = 10;  // Receive entry: break error
   // -------------------------------------------------------------------
   // Sizes, reset values and timing counts
   // -------------------------------------------------------------------
   localparam int TX_WIDTH       = 8;
   localparam int RX_WIDTH       = 11;
   localparam int FIFO_DEPTH     = 16;
   localparam int CNT_W          = 5;             // Holds 0..16
   localparam logic [4:0] HALF   = 5'h08;         // Half-full level
   localparam logic [3:0] START_SAMPLE = 4'h7;    // Eighth tick
   localparam logic [3:0] BIT_END      = 4'hF;    // Sixteenth tick
   localparam int TIMEOUT_BITS   = 32;
   localparam int TIMEOUT_TICKS  = TIMEOUT_BITS * 16;
   localparam logic [7:0]  LINE_H_RST = 8'h70;    // 8 bits, FIFOs on
   localparam logic [15:0] DIV_RST    = 16'h0000;
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PARITY, S_STOP} serial_state_t;
endpackage : uart_pkg

// file: rtl/uart_fifo.sv
// Synchronous first-in first-out store with occupancy count
`timescale 1ns/10ps
module uart_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       push,      // Write, ignored when full
   input  wire logic [WIDTH-1:0]           push_data,
   input  wire logic                       pop,       // Read, ignored when empty
   output logic      [WIDTH-1:0]           head,      // Oldest entry
   output logic      [$clog2(DEPTH):0]     count      // Entries held
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];  // Entry storage
   logic [AW-1:0]    wr_ptr;         // Next slot to write
   logic [AW-1:0]    rd_ptr;         // Oldest slot
   wire              do_push = push && (count != AW'(0) + (AW+1)'(DEPTH));
   wire              do_pop  = pop && (count != '0);

   assign head = store[rd_ptr];

   // Storage write, no reset needed for data
   always_ff @(posedge pclk) begin
      if (do_push) begin
         store[wr_ptr] <= push_data;
      end
   end

   // Pointers and count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= wr_ptr + AW'(do_push);
         rd_ptr <= rd_ptr + AW'(do_pop);
         count  <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
endmodule : uart_fifo

// file: rtl/uart_core.sv
// Serial transceiver core with baud generator, FIFOs and APB registers
`timescale 1ns/10ps
module uart_core (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        dma_tx_push,       // DMA byte into transmit FIFO
   input  wire logic [7:0]  dma_tx_data,
   input  wire logic        dma_rx_pop,        // DMA takes head of receive FIFO
   output logic             dma_tx_room,       // Transmit FIFO not full
   output logic             dma_rx_avail,      // Receive FIFO not empty
   input  wire logic        modem_status_event,// Pulse from outside modem logic
   input  wire logic        serial_rx_line,
   output logic             serial_tx_line,
   output logic             busy,
   output logic             rx_fifo_irq,
   output logic             tx_fifo_irq,
   output logic             rx_timeout_irq,
   output logic             modem_status_irq,
   output logic             combined_irq
);
   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0]  line_h;        // Frame format
   logic [15:0] divisor;       // Baud divisor
   logic [7:0]  ctrl;          // Enable, masks, loopback
   logic        overrun;       // Sticky overrun
   logic        ms_pending;    // Sticky modem status change
   logic [3:0]  raw_irq;       // ms, rx, tx, rt

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire setup    = psel && !penable;
   wire wr_xfer  = psel && penable && pready && pwrite;
   wire rd_xfer  = psel && penable && pready && !pwrite;
   wire hit_data = paddr == uart_pkg::OFF_DATA;
   wire hit_h    = paddr == uart_pkg::OFF_LINE_H;
   wire hit_m    = paddr == uart_pkg::OFF_LINE_M;
   wire hit_l    = paddr == uart_pkg::OFF_LINE_L;
   wire hit_ctrl = paddr == uart_pkg::OFF_CTRL;
   wire hit_stat = paddr == uart_pkg::OFF_STATUS;
   wire hit_int  = paddr == uart_pkg::OFF_INT;
   wire fifo_en  = line_h[uart_pkg::FEN_BIT];
   wire loop_en  = ctrl[uart_pkg::LOOP_BIT];
   wire core_en  = ctrl[uart_pkg::EN_BIT];

   // ----------------------------------------------------------------
   // FIFOs
   // ----------------------------------------------------------------
   logic [7:0]  tx_head;       // Next byte to send
   logic [4:0]  tx_count;      // Transmit occupancy
   logic [10:0] rx_head;       // Oldest received entry
   logic [4:0]  rx_count;      // Receive occupancy
   logic        tx_load;       // Shifter takes head
   logic        rx_done;       // Character complete
   logic [10:0] rx_entry;      // Character with error bits
   // Full level shrinks to one entry when FIFOs are off
   wire [4:0] full_level = fifo_en ? 5'(uart_pkg::FIFO_DEPTH) : 5'h01;
   wire tx_full  = tx_count >= full_level;
   wire rx_full  = rx_count >= full_level;
   wire tx_empty = tx_count == 5'h00;
   wire rx_empty = rx_count == 5'h00;
   wire tx_push  = ((wr_xfer && hit_data) || dma_tx_push) && !tx_full;
   wire [7:0] tx_in = (wr_xfer && hit_data) ? pwdata[7:0] : dma_tx_data;
   wire rx_pop   = (rd_xfer && hit_data) || dma_rx_pop;
   wire rx_push  = rx_done && !rx_full;

   uart_fifo #(.WIDTH(uart_pkg::TX_WIDTH), .DEPTH(uart_pkg::FIFO_DEPTH)) u_tx_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .push      (tx_push),
      .push_data (tx_in),
      .pop       (tx_load),
      .head      (tx_head),
      .count     (tx_count)
   );

   uart_fifo #(.WIDTH(uart_pkg::RX_WIDTH), .DEPTH(uart_pkg::FIFO_DEPTH)) u_rx_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .push      (rx_push),
      .push_data (rx_entry),
      .pop       (rx_pop),
      .head      (rx_head),
      .count     (rx_count)
   );

   // ----------------------------------------------------------------
   // Baud generator
   // ----------------------------------------------------------------
   logic [15:0] baud_cnt;      // Down counter
   logic        baud_tick_x16; // One-cycle tick, sixteen per bit
   // Reload at zero and emit a tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_cnt      <= 16'h0000;
         baud_tick_x16 <= 1'b0;
      end else if (baud_cnt == 16'h0000) begin
         baud_cnt      <= divisor;
         baud_tick_x16 <= 1'b1;
      end else begin
         baud_cnt      <= baud_cnt - 16'h0001;
         baud_tick_x16 <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------
   uart_pkg::serial_state_t tx_state;
   logic [3:0] tx_sub;         // Tick within bit
   logic [2:0] tx_bit;         // Bit index or stop count
   logic [7:0] tx_shift;       // Shifting data
   logic       tx_par;         // Running parity
   logic       tx_out;         // Frame level before break
   wire [2:0] last_bit = 3'(4) + line_h[uart_pkg::WLEN_LO +: 2];
   wire [2:0] last_stop = {2'b00, line_h[uart_pkg::STP2_BIT]};
   wire tx_bit_end = baud_tick_x16 && (tx_sub == uart_pkg::BIT_END);
   assign tx_load = (tx_state == uart_pkg::S_IDLE) && !tx_empty && core_en;

   // Frame sequencer: start, data LSB first, parity, stops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state <= uart_pkg::S_IDLE;
         tx_sub   <= 4'h0;
         tx_bit   <= 3'h0;
         tx_shift <= 8'h00;
         tx_par   <= 1'b0;
         tx_out   <= 1'b1;
      end else begin
         if (baud_tick_x16) begin
            tx_sub <= tx_sub + 4'h1;
         end
         unique case (tx_state)
            uart_pkg::S_IDLE: begin
               tx_out <= 1'b1;
               if (tx_load) begin
                  tx_shift <= tx_head;
                  tx_par   <= !line_h[uart_pkg::EPS_BIT];
                  tx_sub   <= 4'h0;
                  tx_out   <= 1'b0;
                  tx_state <= uart_pkg::S_START;
               end
            end
            uart_pkg::S_START: begin
               if (tx_bit_end) begin
                  tx_out   <= tx_shift[0];
                  tx_par   <= tx_par ^ tx_shift[0];
                  tx_shift <= tx_shift >> 1;
                  tx_bit   <= 3'h0;
                  tx_state <= uart_pkg::S_DATA;
               end
            end
            uart_pkg::S_DATA: begin
               if (tx_bit_end) begin
                  if (tx_bit != last_bit) begin
                     tx_out   <= tx_shift[0];
                     tx_par   <= tx_par ^ tx_shift[0];
                     tx_shift <= tx_shift >> 1;
                     tx_bit   <= tx_bit + 3'h1;
                  end else if (line_h[uart_pkg::PEN_BIT]) begin
                     tx_out   <= tx_par;
                     tx_state <= uart_pkg::S_PARITY;
                  end else begin
                     tx_out   <= 1'b1;
                     tx_bit   <= 3'h0;
                     tx_state <= uart_pkg::S_STOP;
                  end
               end
            end
            uart_pkg::S_PARITY: begin
               if (tx_bit_end) begin
                  tx_out   <= 1'b1;
                  tx_bit   <= 3'h0;
                  tx_state <= uart_pkg::S_STOP;
               end
            end
            uart_pkg::S_STOP: begin
               if (tx_bit_end) begin
                  if (tx_bit != last_stop) begin
                     tx_bit <= tx_bit + 3'h1;
                  end else begin
                     tx_state <= uart_pkg::S_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Receiver
   // ----------------------------------------------------------------
   logic       rx_meta;        // First synchroniser stage
   logic       rx_sync;        // Second synchroniser stage
   uart_pkg::serial_state_t rx_state;
   logic [3:0] rx_sub;         // Tick within bit
   logic [2:0] rx_bit;         // Data bit index
   logic [7:0] rx_shift;       // Assembled byte
   logic       rx_par;         // Running parity
   logic       rx_zero;        // Every bit so far low
   wire rx_in = loop_en ? serial_tx_line : rx_sync;
   wire rx_sample = baud_tick_x16 && (rx_sub == uart_pkg::BIT_END);
   wire [7:0] rx_byte = rx_shift >> (3'(7) - last_bit);

   // Two-stage synchroniser on the line input
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
      end else begin
         rx_meta <= serial_rx_line;
         rx_sync <= rx_meta;
      end
   end

   // Frame receiver with start validation and error capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state <= uart_pkg::S_IDLE;
         rx_sub   <= 4'h0;
         rx_bit   <= 3'h0;
         rx_shift <= 8'h00;
         rx_par   <= 1'b0;
         rx_zero  <= 1'b0;
         rx_done  <= 1'b0;
         rx_entry <= 11'h000;
      end else begin
         rx_done <= 1'b0;
         if (baud_tick_x16) begin
            rx_sub <= rx_sub + 4'h1;
         end
         unique case (rx_state)
            uart_pkg::S_IDLE: begin
               if (core_en && !rx_in) begin
                  rx_sub   <= 4'h0;
                  rx_state <= uart_pkg::S_START;
               end
            end
            uart_pkg::S_START: begin
               if (baud_tick_x16 && rx_sub == uart_pkg::START_SAMPLE) begin
                  rx_sub   <= 4'h0;
                  rx_bit   <= 3'h0;
                  rx_par   <= !line_h[uart_pkg::EPS_BIT];
                  rx_zero  <= 1'b1;
                  rx_state <= rx_in ? uart_pkg::S_IDLE : uart_pkg::S_DATA;
               end
            end
            uart_pkg::S_DATA: begin
               if (rx_sample) begin
                  rx_shift <= {rx_in, rx_shift[7:1]};
                  rx_par   <= rx_par ^ rx_in;
                  rx_zero  <= rx_zero && !rx_in;
                  rx_bit   <= rx_bit + 3'h1;
                  if (rx_bit == last_bit) begin
                     rx_state <= line_h[uart_pkg::PEN_BIT] ? uart_pkg::S_PARITY : uart_pkg::S_STOP;
                  end
               end
            end
            uart_pkg::S_PARITY: begin
               if (rx_sample) begin
                  rx_par   <= rx_par ^ rx_in;
                  rx_zero  <= rx_zero && !rx_in;
                  rx_state <= uart_pkg::S_STOP;
               end
            end
            uart_pkg::S_STOP: begin
               if (rx_sample) begin
                  rx_entry[7:0]               <= rx_byte;
                  rx_entry[uart_pkg::FE_BIT]  <= !rx_in;
                  // Running parity ends at zero for a good character, so a one is an error
                  rx_entry[uart_pkg::PE_BIT]  <= line_h[uart_pkg::PEN_BIT] && rx_par;
                  rx_entry[uart_pkg::BE_BIT]  <= rx_zero && !rx_in;
                  rx_done  <= 1'b1;
                  rx_state <= uart_pkg::S_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Receive timeout: ticks since last FIFO activity
   // ----------------------------------------------------------------
   logic [9:0] idle_ticks;     // Counts to the timeout
   logic       timeout;        // Latched timeout
   // Restart on push or pop, clear when empty
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_ticks <= 10'h000;
         timeout    <= 1'b0;
      end else if (rx_empty || rx_push || rx_pop) begin
         idle_ticks <= 10'h000;
         timeout    <= timeout && !rx_empty;
      end else if (baud_tick_x16) begin
         if (idle_ticks == 10'(uart_pkg::TIMEOUT_TICKS - 1)) begin
            timeout <= 1'b1;
         end else begin
            idle_ticks <= idle_ticks + 10'h001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Requests and status
   // ----------------------------------------------------------------
   wire rx_level = fifo_en ? (rx_count >= uart_pkg::HALF) : !rx_empty;
   wire tx_level = fifo_en ? (tx_count <= uart_pkg::HALF) : tx_empty;
   wire [3:0] next_raw = {timeout, tx_level, rx_level, ms_pending};
   wire [3:0] masked   = raw_irq & ctrl[uart_pkg::MASK_LO +: 4];
   wire [7:0] status   = {tx_empty, rx_full, tx_full, rx_empty, busy, 2'b00, overrun};
   wire [31:0] rd_mux  = hit_data ? {21'h000000, rx_head} :
                         hit_h    ? {24'h000000, line_h} :
                         hit_m    ? {24'h000000, divisor[15:8]} :
                         hit_l    ? {24'h000000, divisor[7:0]} :
                         hit_ctrl ? {24'h000000, ctrl} :
                         hit_stat ? {24'h000000, status} :
                         hit_int  ? {24'h000000, masked, raw_irq} : 32'h00000000;

   // Register writes and sticky flags, a new event wins over a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_h     <= uart_pkg::LINE_H_RST;
         divisor    <= uart_pkg::DIV_RST;
         ctrl       <= uart_pkg::CTRL_RST;
         overrun    <= 1'b0;
         ms_pending <= 1'b0;
      end else begin
         if (wr_xfer && hit_h) line_h <= pwdata[7:0];
         if (wr_xfer && hit_m) divisor[15:8] <= pwdata[7:0];
         if (wr_xfer && hit_l) divisor[7:0] <= pwdata[7:0];
         if (wr_xfer && hit_ctrl) ctrl <= pwdata[7:0];
         overrun <= (rx_done && rx_full) || (overrun && !(wr_xfer && hit_stat && pwdata[uart_pkg::OVR_BIT]));
         ms_pending <= modem_status_event || (ms_pending && !(wr_xfer && hit_int));
      end
   end

   // APB answer: data latched in setup, ready in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= 1'b0;
         if (setup && !pwrite) prdata <= rd_mux;
      end
   end

   // Registered pin, request and DMA outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_tx_line   <= 1'b1;
         busy             <= 1'b0;
         raw_irq          <= 4'h0;
         rx_fifo_irq      <= 1'b0;
         tx_fifo_irq      <= 1'b0;
         rx_timeout_irq   <= 1'b0;
         modem_status_irq <= 1'b0;
         combined_irq     <= 1'b0;
         dma_tx_room      <= 1'b0;
         dma_rx_avail     <= 1'b0;
      end else begin
         serial_tx_line   <= tx_out && !line_h[uart_pkg::BRK_BIT];
         busy             <= !tx_empty || tx_push || (tx_state != uart_pkg::S_IDLE);
         raw_irq          <= next_raw;
         modem_status_irq <= masked[0];
         rx_fifo_irq      <= masked[1];
         tx_fifo_irq      <= masked[2];
         rx_timeout_irq   <= masked[3];
         combined_irq     <= |masked;
         dma_tx_room      <= !tx_full;
         dma_rx_avail     <= !rx_empty;
      end
   end
endmodule : uart_core

// file: bench/uart_core_asserts.sv
// Port-level checker for the serial core
`timescale 1ns/10ps
module uart_core_asserts (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       serial_tx_line,
   input wire logic       busy,
   input wire logic       dma_tx_room,
   input wire logic       dma_rx_avail,
   input wire logic       rx_fifo_irq,
   input wire logic       tx_fifo_irq,
   input wire logic       rx_timeout_irq,
   input wire logic       modem_status_irq,
   input wire logic       combined_irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire any_irq = rx_fifo_irq | tx_fifo_irq | rx_timeout_irq | modem_status_irq;  // Masked requests
   pready_slot_a: assert property (psel && !penable |=> pready) else $error("no bus answer");
   busy_set_a: assert property (psel && penable && pwrite && pready && paddr == 8'h00 |=> busy)
      else $error("busy not raised");
   low_bit_a: assert property ($fell(serial_tx_line) |-> !serial_tx_line [*8])
      else $error("low level too short");
   high_bit_a: assert property ($rose(serial_tx_line) |-> serial_tx_line [*8])
      else $error("high level too short");
   full_busy_a: assert property ($past(presetn) && !dma_tx_room |-> busy)
      else $error("full but idle");
   irq_or_a: assert property (any_irq |-> ##[0:1] combined_irq)
      else $error("combined low");
   irq_none_a: assert property (!any_irq [*2] |-> !combined_irq)
      else $error("combined high");
   rx_irq_data_a: assert property ($rose(rx_fifo_irq) |-> dma_rx_avail)
      else $error("rx request on empty");
   rt_irq_data_a: assert property ($rose(rx_timeout_irq) |-> dma_rx_avail)
      else $error("timeout on empty");
endmodule : uart_core_asserts
bind uart_core uart_core_asserts i_uart_core_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pready, .serial_tx_line, .busy, .dma_tx_room, .dma_rx_avail, .rx_fifo_irq, .tx_fifo_irq,
   .rx_timeout_irq, .modem_status_irq, .combined_irq);

// file: bench/serial_peer.sv
// Far-side serial device framing bytes onto the receive line
`timescale 1ns/10ps
module serial_peer (
   input  wire logic pclk,
   output logic      serial_rx_line
);
   initial serial_rx_line = 1'b1;  // Marking level between frames
   // Bit time is 16 cycles; a low stop is cut short so the line is idle soon after
   task automatic send(input logic [7:0] d, input logic stop);
      serial_rx_line <= 1'b0;
      repeat (16) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         serial_rx_line <= d[i];
         repeat (16) @(posedge pclk);
      end
      serial_rx_line <= stop;
      repeat (stop ? 16 : 11) @(posedge pclk);
      serial_rx_line <= 1'b1;
      repeat (40) @(posedge pclk);
   endtask : send
endmodule : serial_peer

// file: bench/uart_core_test.sv
// Self-checking bench for the serial core
`timescale 1ns/10ps
module uart_core_test;
   logic        pclk, presetn, psel, penable, pwrite, pready, rxl, txl, busy;
   logic        rxi, txi, rti, msi, ci, room, avail, slverr, dpush, ms_ev;
   logic [7:0]  paddr, dtx;
   logic [7:0]  b [8];     // Random payload
   logic [31:0] pwdata, prdata;
   logic [31:0] exp_q [$];  // Expected read words
   int          n_fail = 0, n_tests = 0, seed = 32'h711082eb;
   uart_core i_uart_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr(slverr), .dma_tx_push(dpush), .dma_tx_data(dtx), .dma_rx_pop(1'b0), .dma_tx_room(room),
      .dma_rx_avail(avail), .modem_status_event(ms_ev), .serial_rx_line(rxl), .serial_tx_line(txl), .busy,
      .rx_fifo_irq(rxi), .tx_fifo_irq(txi), .rx_timeout_irq(rti), .modem_status_irq(msi), .combined_irq(ci));
   serial_peer i_serial_peer (.pclk, .serial_rx_line(rxl));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish;
      if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd
   // Monitor: each completed read takes the oldest expectation
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) check("prdata", prdata, exp_q.pop_front());
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      tally_and_finish;
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, dpush, dtx, ms_ev} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h04, 32'h70);
      rd(8'h14, 32'h90);
      rd(8'h1C, 32'h0);
      apb(1'b1, 8'h10, 32'hD1);
      foreach (b[i]) begin
         b[i] = $random(seed);
         apb(1'b1, 8'h00, {24'h0, b[i]});
      end
      check("busy", busy, 32'h1);
      for (int k = 0; k < 4000 && rti !== 1'b1; k++) @(posedge pclk);
      check("irqs", {rxi, rti, ci, txi, msi}, 32'h1C);
      foreach (b[i]) rd(8'h00, {24'h0, b[i]});
      repeat (4) @(posedge pclk);
      check("drained", {busy, rxi, rti}, 32'h0);
      apb(1'b1, 8'h10, 32'h51);
      i_serial_peer.send(b[0], 1'b1);
      i_serial_peer.send(b[1], 1'b0);
      i_serial_peer.send(8'h00, 1'b0);
      rd(8'h00, {24'h0, b[0]});
      rd(8'h00, {21'h0, b[1] == 8'h00, 2'b01, b[1]});
      rd(8'h00, 32'h500);
      // FIFOs off, even parity, divisor 1, loopback: the DMA byte overruns
      apb(1'b1, 8'h04, 32'h66);
      apb(1'b1, 8'h0C, 32'h01);
      apb(1'b1, 8'h10, 32'h81);
      apb(1'b1, 8'h00, {24'h0, b[2]});
      @(posedge pclk);
      {dpush, dtx} <= {1'b1, b[3]};
      @(posedge pclk);
      dpush <= 1'b0;
      for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge pclk);
      check("dma", {slverr, room, avail}, 32'h3);
      rd(8'h14, 32'hC1);
      rd(8'h00, {24'h0, b[2]});
      apb(1'b1, 8'h14, 32'h01);
      rd(8'h14, 32'h90);
      // Modem and transmit requests unmasked, one modem event pulse
      apb(1'b1, 8'h10, 32'h29);
      ms_ev <= 1'b1;
      @(posedge pclk);
      ms_ev <= 1'b0;
      repeat (3) @(posedge pclk);
      check("irqs", {rxi, rti, ci, txi, msi}, 32'h7);
      tally_and_finish;
   end
endmodule : uart_core_test
